// ---- bench/acmp_checker.sv ----
`timescale 1ns/100ps
module acmp_checker (
	// clock and reset
	input logic aclk,
	input logic aresetn,
	// register bus
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	// comparator
	input logic ana_pos_above,
	input logic ana_neg_above,
	input logic neg_ref_enable,
	input logic comparator_power_down,
	input logic cmp_irq_source,
	input logic cmp_out_pin
);
// ----
// rules
// ----
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
AST_HIGH: assert property (
	(ana_pos_above && !ana_neg_above && !comparator_power_down)[*4] |-> cmp_irq_source)
	else $error("result not high");
AST_LOW: assert property (
	(ana_neg_above && !ana_pos_above)[*4] |-> !cmp_irq_source) else $error("result not low");
AST_HOLD: assert property (
	(!ana_pos_above && !ana_neg_above && !comparator_power_down)[*5] |-> $stable(cmp_irq_source))
	else $error("result moved");
AST_PD: assert property (
	comparator_power_down[*2] |-> !cmp_irq_source) else $error("result while down");
AST_PIN: assert property (
	cmp_out_pin == cmp_irq_source) else $error("pin differs");
AST_REF: assert property (
	comparator_power_down[*2] |-> !neg_ref_enable) else $error("ref on while down");
AST_BRSP: assert property (
	s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
	else $error("no write response");
AST_RDV: assert property (
	s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
AST_RDONE: assert property (
	s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready) else $error("read stuck");
endmodule // acmp_checker

// ---- bench/acmp_front_model.sv ----
`timescale 1ns/100ps
module acmp_front_model #(
	parameter int HYST_MV = 20
) (
	// controls from the block
	input logic pos_select_temp,
	input logic neg_ref_enable,
	input logic [5:0] ref_level_code,
	input logic comparator_power_down,
	// analog levels in mV
	input int pin_pos_mv,
	input int pin_neg_mv,
	input int temp_mv,
	// decisions
	output logic ana_pos_above,
	output logic ana_neg_above
);
int p;
int n;
always_comb begin
	p = pos_select_temp ? temp_mv : pin_pos_mv;
	n = neg_ref_enable ? ref_level_code * 200 : pin_neg_mv;
	ana_pos_above = !comparator_power_down && (p > n + HYST_MV);
	ana_neg_above = !comparator_power_down && (n > p + HYST_MV);
end
endmodule // acmp_front_model

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`include "acmp_defs.vh"
module tb;
logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
logic s_axi_arready, s_axi_rvalid, ana_pos_above, ana_neg_above, pos_select_temp;
logic neg_ref_enable, comparator_power_down, cmp_irq_source, cmp_out_pin;
logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
logic [3:0] s_axi_wstrb = 4'hf;
logic [1:0] s_axi_bresp, s_axi_rresp, rs;
logic [5:0] ref_level_code;
int pin_pos_mv = 0, pin_neg_mv = 0, temp_mv = 0, err_count = 0, cmp_count = 0;
acmp_control #(.SMALL_PKG(0)) i_acmp_control (.*);
acmp_front_model i_acmp_front_model (.*);
logic [5:0] small_lvl;
acmp_control #(.SMALL_PKG(1)) i_acmp_control_small (.*, .s_axi_awready(), .s_axi_wready(),
	.s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
	.s_axi_rvalid(), .pos_select_temp(), .neg_ref_enable(), .ref_level_code(small_lvl),
	.comparator_power_down(), .cmp_irq_source(), .cmp_out_pin());
// ----
// helpers
// ----
task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
	cmp_count++;
	if (got !== exp) begin
		err_count++;
		$display("[ERR] %s exp %h got %h", nm, exp, got);
	end
endtask
task automatic final_report;
	if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
endtask
task automatic tmo;
	err_count++;
	final_report();
endtask
task automatic wr(input logic [11:0] a, input logic [7:0] d);
	int n;
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= {24'h0, d};
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
		@(posedge aclk);
		if (s_axi_awready) s_axi_awvalid <= 1'b0;
		if (s_axi_wready) s_axi_wvalid <= 1'b0;
	end
	if (n == 50) tmo();
	rs = s_axi_bresp;
	s_axi_bready <= 1'b0;
endtask
task automatic rd(input logic [11:0] a);
	int n;
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
		@(posedge aclk);
		if (s_axi_arready) s_axi_arvalid <= 1'b0;
	end
	if (n == 50) tmo();
	v = s_axi_rdata;
	rs = s_axi_rresp;
	s_axi_rready <= 1'b0;
endtask
task automatic drv(input int p, input logic e);
	@(posedge aclk);
	pin_pos_mv <= p;
	repeat (5) @(posedge aclk);
	chk("irq", cmp_irq_source, e);
	chk("pin", cmp_out_pin, e);
endtask
// ----
// scenarios
// ----
task automatic sc_reset;
	rd(`ACMP_CTRL_OFF);
	chk("ctrl", v, 32'h14);
	chk("psel", pos_select_temp, 1'b0);
	chk("nref", neg_ref_enable, 1'b0);
	chk("lvl", ref_level_code, 6'h05);
	chk("lvl6", small_lvl, 6'h14);
endtask
task automatic sc_regs;
	wr(`ACMP_CTRL_OFF, 8'he4);
	chk("wresp", rs, 2'b00);
	rd(`ACMP_CTRL_OFF);
	chk("ctrl", v, 32'he4);
	chk("psel", pos_select_temp, 1'b1);
	chk("nref", neg_ref_enable, 1'b1);
	chk("lvl", ref_level_code, 6'h09);
	chk("lvl6", small_lvl, 6'h24);
	wr(12'hf9c, 8'h00);
	chk("bad wresp", rs, 2'b10);
	rd(12'hf9c);
	chk("bad rresp", rs, 2'b10);
endtask
task automatic sc_cmp;
	wr(`ACMP_CTRL_OFF, 8'h54);
	drv(1500, 1'b1);
	drv(1010, 1'b1);
	drv(500, 1'b0);
	drv(990, 1'b0);
	temp_mv <= 1300;
	wr(`ACMP_CTRL_OFF, 8'hd4);
	drv(500, 1'b1);
	rd(`ACMP_STAT_OFF);
	chk("stat", v, 32'h3);
	wr(`ACMP_STAT_OFF, 8'h02);
	rd(`ACMP_STAT_OFF);
	chk("stat clr", v, 32'h1);
endtask
task automatic sc_pd;
	wr(`ACMP_PWR_OFF, 8'h01);
	drv(500, 1'b0);
	chk("nref", neg_ref_enable, 1'b0);
	wr(`ACMP_PWR_OFF, 8'h00);
	drv(500, 1'b1);
endtask
initial begin
	forever #5 aclk = ~aclk;
end
initial begin
	repeat (20) @(posedge aclk);
	aresetn <= 1'b1;
	sc_reset();
	sc_regs();
	sc_cmp();
	sc_pd();
	final_report();
end
endmodule // tb
bind acmp_control acmp_checker i_acmp_checker (.*);

// ---- rtl/acmp_control.v ----
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "acmp_defs.vh"

module acmp_control #(
	parameter SMALL_PKG = 0
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [`ACMP_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [`ACMP_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// analog front end: raw comparator decisions
	input wire ana_pos_above,
	input wire ana_neg_above,
	// analog front end controls
	output reg pos_select_temp,
	output reg neg_ref_enable,
	output reg [5:0] ref_level_code,
	output reg comparator_power_down,
	// result
	output reg cmp_irq_source,
	output reg cmp_out_pin
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] ctrl_r;
	reg pwr_down_r;
	reg [1:0] pos_sync_r;
	reg [1:0] neg_sync_r;
	reg cmp_state_r;
	reg chg_r;
	reg [`ACMP_ADDR_W-1:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_have_r;
	reg w_have_r;
	reg [7:0] ctrl_nxt;
	reg cmp_nxt;

	wire pos_above_s = pos_sync_r[1];
	wire neg_above_s = neg_sync_r[1];

	// clears the two unused low bits on the large package
	function [7:0] ctrl_mask;
		input [7:0] v;
		begin
			if (SMALL_PKG != 0) begin
				ctrl_mask = v;
			end else begin
				ctrl_mask = {v[7:2], 2'b00};
			end
		end
	endfunction

	function [5:0] level_of;
		input [7:0] v;
		begin
			if (SMALL_PKG != 0) begin
				level_of = v[`ACMP_LVL_HI:`ACMP_LVL6_LO];
			end else begin
				level_of = {2'b00, v[`ACMP_LVL_HI:`ACMP_LVL4_LO]};
			end
		end
	endfunction

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	// exact word match only; the rest of the page answers with an error
	function mapped;
		input [`ACMP_ADDR_W-1:0] a;
		begin
			mapped = (a == `ACMP_CTRL_OFF) || (a == `ACMP_STAT_OFF) || (a == `ACMP_PWR_OFF);
		end
	endfunction

	// unmapped words read as zero so software never sees stale data
	function [31:0] rd_word;
		input [`ACMP_ADDR_W-1:0] a;
		input [7:0] ctrl;
		input chg;
		input res;
		input pwr;
		begin
			case (a)
			`ACMP_CTRL_OFF: begin
				rd_word = {24'h000000, ctrl};
			end
			`ACMP_STAT_OFF: begin
				rd_word = {30'h0, chg, res};
			end
			`ACMP_PWR_OFF: begin
				rd_word = {31'h0, pwr};
			end
			default: begin
				rd_word = 32'h00000000;
			end
			endcase
		end
	endfunction

	// ----------------------------------------
	// comparator output with hysteresis
	// ----------------------------------------
	// analog front end reports lead beyond the hysteresis margin; synced first
	always @(posedge aclk) begin
		if (!aresetn) begin
			pos_sync_r <= 2'b00;
		end else begin
			pos_sync_r <= {pos_sync_r[0], ana_pos_above};
		end
	end

	// each lead is synced alone; a both-high overlap is read as a hold
	always @(posedge aclk) begin
		if (!aresetn) begin
			neg_sync_r <= 2'b00;
		end else begin
			neg_sync_r <= {neg_sync_r[0], ana_neg_above};
		end
	end

	always @* begin
		cmp_nxt = cmp_state_r;
		if (pwr_down_r) begin
			cmp_nxt = 1'b0;
		end else if (pos_above_s && !neg_above_s) begin
			cmp_nxt = 1'b1;
		end else if (neg_above_s && !pos_above_s) begin
			cmp_nxt = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			cmp_state_r <= 1'b0;
		end else begin
			cmp_state_r <= cmp_nxt;
		end
	end

	// no masking during settling: glitches reach the irq on purpose
	always @(posedge aclk) begin
		if (!aresetn) begin
			cmp_irq_source <= 1'b0;
		end else begin
			cmp_irq_source <= cmp_nxt;
		end
	end

	// pin copy is its own flop so the pad path can be placed near the pad
	always @(posedge aclk) begin
		if (!aresetn) begin
			cmp_out_pin <= 1'b0;
		end else begin
			cmp_out_pin <= cmp_nxt;
		end
	end

	// ----------------------------------------
	// analog controls
	// ----------------------------------------
	// own level field only; the converter reference is elsewhere
	always @(posedge aclk) begin
		if (!aresetn) begin
			pos_select_temp <= 1'b0;
		end else begin
			pos_select_temp <= ctrl_r[`ACMP_POS_SEL_BIT];
		end
	end

	// reference is dropped while powered down to save its bias current
	always @(posedge aclk) begin
		if (!aresetn) begin
			neg_ref_enable <= 1'b0;
		end else begin
			neg_ref_enable <= ctrl_r[`ACMP_NEG_SEL_BIT] & ~pwr_down_r;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ref_level_code <= level_of(ctrl_mask(`ACMP_CTRL_RESET));
		end else begin
			ref_level_code <= level_of(ctrl_r);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			comparator_power_down <= 1'b0;
		end else begin
			comparator_power_down <= pwr_down_r;
		end
	end

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------
	// one write at a time: both channels stay closed until the response is taken
	wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	// writes touch byte lane 0 only; a cleared strobe leaves the register alone
	wire wr_lane0 = wr_go && wstrb_r[0];
	wire wr_ctrl = wr_lane0 && (awaddr_r == `ACMP_CTRL_OFF);
	wire wr_stat = wr_lane0 && (awaddr_r == `ACMP_STAT_OFF);

	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			ctrl_nxt = ctrl_mask(wdata_r[7:0]);
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACMP_RESP_OKAY;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= {`ACMP_ADDR_W{1'b0}};
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			pwr_down_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_r <= s_axi_awaddr;
				aw_have_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_have_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_r)
				`ACMP_CTRL_OFF, `ACMP_STAT_OFF: begin
					s_axi_bresp <= `ACMP_RESP_OKAY;
				end
				`ACMP_PWR_OFF: begin
					s_axi_bresp <= `ACMP_RESP_OKAY;
					if (wstrb_r[0]) begin
						pwr_down_r <= wdata_r[`ACMP_PWR_DOWN_BIT];
					end
				end
				default: begin
					s_axi_bresp <= `ACMP_RESP_SLVERR;
				end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= ctrl_mask(`ACMP_CTRL_RESET);
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// change flag: set beats write-one-to-clear in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			chg_r <= 1'b0;
		end else if (cmp_nxt != cmp_state_r) begin
			chg_r <= 1'b1;
		end else if (wr_stat && wdata_r[`ACMP_STAT_CHG_BIT]) begin
			chg_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ACMP_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word(s_axi_araddr, ctrl_r, chg_r, cmp_state_r, pwr_down_r);
				s_axi_rresp <= mapped(s_axi_araddr) ? `ACMP_RESP_OKAY : `ACMP_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // acmp_control

// ---- rtl/acmp_defs.vh ----
`ifndef ACMP_DEFS_VH
`define ACMP_DEFS_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ACMP_ADDR_W 12
`define ACMP_CTRL_OFF 12'hf90
`define ACMP_STAT_OFF 12'hf94
`define ACMP_PWR_OFF 12'hf98

// ----------------------------------------
// control register fields
// ----------------------------------------
`define ACMP_CTRL_RESET 8'h14
`define ACMP_POS_SEL_BIT 7
`define ACMP_NEG_SEL_BIT 6
`define ACMP_LVL_HI 5
`define ACMP_LVL4_LO 2
`define ACMP_LVL6_LO 0
`define ACMP_LVL4_MAX 4'h9

// ----------------------------------------
// status and power fields
// ----------------------------------------
`define ACMP_STAT_OUT_BIT 0
`define ACMP_STAT_CHG_BIT 1
`define ACMP_PWR_DOWN_BIT 0
`define ACMP_PWR_RESET 8'h00

// ----------------------------------------
// axi responses
// ----------------------------------------
`define ACMP_RESP_OKAY 2'b00
`define ACMP_RESP_SLVERR 2'b10

`endif
